/* File: tcmu_pkg.sv */
// Constants and register map of the timer compare match unit
// Behaviour
// - Compare value against timer count every cycle
// - Match does toggle, set, clear, trigger, interrupt
// - Interrupt flag set with the match action
// - Zero control write clears compare latch only
// - Pin function routable by route select registers
// - Compare identical in every unit instance
// - Compare value held as low, high bytes
// - Enhanced output config only in enhanced units
// - Unimplemented bits read as zero
// - Codes 1010, 1011 leave the pin alone
// - Trigger at match, timer reset next tick
// - No overflow flag; value change cancels reset
`default_nettype none
package tcmu_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 16;
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_VAL_LO  = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_VAL_HI  = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_MASK    = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_ROUTE_A = 3'h5;
	localparam logic [ADDR_W-1:0] OFS_ROUTE_B = 3'h6;
	// Control field positions
	localparam int MODE_LSB = 0;
	localparam int MODE_W   = 4;
	localparam int DUTY_LSB = 4;
	localparam int ECFG_LSB = 6;
	// Control bits kept in a standard unit; enhanced keeps all
	localparam logic [7:0] CTRL_STD_MASK = 8'h3f;
	localparam logic [7:0] CTRL_ENH_MASK = 8'hff;
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] VAL_RST   = 8'h00;
	localparam logic [7:0] MASK_RST  = 8'h00;
	localparam logic [7:0] ROUTE_RST = 8'h00;
	// Status and mask bit positions
	localparam int ST_MATCH = 0;
	localparam int ST_SEV   = 1;
	localparam int ST_W     = 2;
	localparam logic [ST_W-1:0] ST_RST = 2'h0;
	// Operating mode codes
	localparam logic [3:0] MODE_OFF    = 4'h0;
	localparam logic [3:0] MODE_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_SET    = 4'h8;
	localparam logic [3:0] MODE_CLEAR  = 4'h9;
	localparam logic [3:0] MODE_SWI    = 4'ha;
	localparam logic [3:0] MODE_SEV    = 4'hb;
endpackage
`default_nettype wire

/* File: tcmu_byte_reg.sv */
// Software writable byte register with synchronous reset
`timescale 1ns/1ns
`default_nettype none
module tcmu_byte_reg #(
	parameter int         WIDTH = 8,
	parameter logic [7:0] RST   = 8'h00,
	parameter logic [7:0] KEEP  = 8'hff
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             wr_in,
	input  wire logic [WIDTH-1:0] data_in,
	output logic      [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] val_q;
	logic [WIDTH-1:0] val_d;

	always_comb
	begin
		val_d = val_q;
		if (wr_in)
		begin
			// Bits not kept never store, so they read back as zero
			val_d = data_in & KEEP[WIDTH-1:0];
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			val_q <= RST[WIDTH-1:0];
		else
			val_q <= val_d;
	end

	assign q_out = val_q;
endmodule
`default_nettype wire

/* File: tcmu_unit.sv */
// Compare match unit: registers, match detect, pin latch, trigger
`timescale 1ns/1ns
`default_nettype none
module tcmu_unit
	import tcmu_pkg::*;
#(
	parameter bit ENHANCED = 1'b1
) (
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire logic [tcmu_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [tcmu_pkg::DATA_W-1:0] wdata_in,
	input  wire logic                  wr_in,
	input  wire logic                  rd_in,
	output logic      [tcmu_pkg::DATA_W-1:0] rdata_out,
	input  wire logic [tcmu_pkg::CNT_W-1:0]  timer_count_in,
	input  wire logic                  timer_tick_in,
	input  wire logic                  adc_enable_in,
	output logic                       compare_out,
	output logic                       pin_drive_out,
	output logic                       special_event_out,
	output logic                       adc_start_out,
	output logic                       timer_reset_out,
	output logic                       match_flag_out,
	output logic                       irq_out,
	output logic      [7:0]            pin_route_a_out,
	output logic      [7:0]            pin_route_b_out
);
	import tcmu_pkg::*;

	localparam logic [7:0] CTRL_KEEP =
		ENHANCED ? CTRL_ENH_MASK : CTRL_STD_MASK;
	// Mask keeps only the bits that status implements
	localparam logic [7:0] MASK_KEEP = {{(8-ST_W){1'b0}}, {ST_W{1'b1}}};

	logic [7:0]      ctrl_q;
	logic [7:0]      val_lo_q;
	logic [7:0]      val_hi_q;
	logic [7:0]      mask_q;
	logic [3:0]      mode;
	logic            wr_ctrl;
	logic            wr_lo;
	logic            wr_hi;
	logic            wr_val;
	logic            equal;
	logic            cmp_mode;
	logic            match_ev;
	logic            sev_ev;
	logic            equal_q;
	logic            equal_d;
	logic            latch_q;
	logic            latch_d;
	logic            pend_q;
	logic            pend_d;
	logic            sev_q;
	logic            sev_d;
	logic            adc_q;
	logic            adc_d;
	logic            trst_q;
	logic            trst_d;
	logic [ST_W-1:0] st_q;
	logic [ST_W-1:0] st_d;
	logic [7:0]      rdata_q;
	logic [7:0]      rdata_d;

	assign wr_ctrl = wr_in && (addr_in == OFS_CTRL);
	assign wr_lo   = wr_in && (addr_in == OFS_VAL_LO);
	assign wr_hi   = wr_in && (addr_in == OFS_VAL_HI);
	assign wr_val  = wr_lo || wr_hi;

	// Standard units drop the enhanced config bits at the store
	tcmu_byte_reg #(.WIDTH(8), .RST(CTRL_RST), .KEEP(CTRL_KEEP))
	u_ctrl (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.wr_in   (wr_ctrl),
		.data_in (wdata_in),
		.q_out   (ctrl_q)
	);

	tcmu_byte_reg #(.WIDTH(8), .RST(VAL_RST)) u_val_lo (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.wr_in   (wr_lo),
		.data_in (wdata_in),
		.q_out   (val_lo_q)
	);

	tcmu_byte_reg #(.WIDTH(8), .RST(VAL_RST)) u_val_hi (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.wr_in   (wr_hi),
		.data_in (wdata_in),
		.q_out   (val_hi_q)
	);

	tcmu_byte_reg #(.WIDTH(8), .RST(MASK_RST), .KEEP(MASK_KEEP))
	u_mask (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.wr_in   (wr_in && (addr_in == OFS_MASK)),
		.data_in (wdata_in),
		.q_out   (mask_q)
	);

	tcmu_byte_reg #(.WIDTH(8), .RST(ROUTE_RST)) u_route_a (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.wr_in   (wr_in && (addr_in == OFS_ROUTE_A)),
		.data_in (wdata_in),
		.q_out   (pin_route_a_out)
	);

	tcmu_byte_reg #(.WIDTH(8), .RST(ROUTE_RST)) u_route_b (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.wr_in   (wr_in && (addr_in == OFS_ROUTE_B)),
		.data_in (wdata_in),
		.q_out   (pin_route_b_out)
	);

	assign mode = ctrl_q[MODE_LSB +: MODE_W];
	assign cmp_mode = (mode == MODE_TOGGLE) || (mode == MODE_SET) ||
		(mode == MODE_CLEAR) || (mode == MODE_SWI) ||
		(mode == MODE_SEV);
	assign equal = ({val_hi_q, val_lo_q} == timer_count_in);
	// Timer holds a count for many clocks; act once per new equality
	assign match_ev = cmp_mode && equal && !equal_q;
	assign sev_ev   = match_ev && (mode == MODE_SEV);

	always_comb
	begin
		equal_d = equal;
		latch_d = latch_q;
		if (wr_ctrl && (wdata_in == 8'h00))
			latch_d = 1'b0;
		else if (match_ev)
		begin
			case (mode)
				MODE_TOGGLE: latch_d = !latch_q;
				MODE_SET:    latch_d = 1'b1;
				MODE_CLEAR:  latch_d = 1'b0;
				default:     latch_d = latch_q;
			endcase
		end
	end

	always_comb
	begin
		sev_d  = sev_ev;
		adc_d  = sev_ev && adc_enable_in;
		// Any value write between trigger and tick drops the reset
		trst_d = pend_q && timer_tick_in && !wr_val;
		pend_d = pend_q;
		if (timer_tick_in || wr_val)
			pend_d = 1'b0;
		if (sev_ev)
			pend_d = 1'b1;
	end

	always_comb
	begin
		st_d = st_q;
		if (wr_in && (addr_in == OFS_STATUS))
			st_d = st_q & ~wdata_in[ST_W-1:0];
		// Hardware set wins over a clear in the same cycle
		st_d[ST_MATCH] = st_d[ST_MATCH] | match_ev;
		st_d[ST_SEV]   = st_d[ST_SEV] | sev_ev;
	end

	always_comb
	begin
		rdata_d = 8'h00;
		if (rd_in)
		begin
			case (addr_in)
				OFS_CTRL:    rdata_d = ctrl_q;
				OFS_VAL_LO:  rdata_d = val_lo_q;
				OFS_VAL_HI:  rdata_d = val_hi_q;
				OFS_STATUS:  rdata_d = {{(8-ST_W){1'b0}}, st_q};
				OFS_MASK:    rdata_d = mask_q;
				OFS_ROUTE_A: rdata_d = pin_route_a_out;
				OFS_ROUTE_B: rdata_d = pin_route_b_out;
				default:     rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			equal_q <= 1'b0;
			latch_q <= 1'b0;
			pend_q  <= 1'b0;
			sev_q   <= 1'b0;
			adc_q   <= 1'b0;
			trst_q  <= 1'b0;
			st_q    <= ST_RST;
			rdata_q <= 8'h00;
		end
		else
		begin
			equal_q <= equal_d;
			latch_q <= latch_d;
			pend_q  <= pend_d;
			sev_q   <= sev_d;
			adc_q   <= adc_d;
			trst_q  <= trst_d;
			st_q    <= st_d;
			rdata_q <= rdata_d;
		end
	end

	assign compare_out       = latch_q;
	// Pin direction stays with software; this only claims the pin
	assign pin_drive_out     = (mode == MODE_TOGGLE) ||
		(mode == MODE_SET) || (mode == MODE_CLEAR);
	assign special_event_out = sev_q;
	assign adc_start_out     = adc_q;
	// Overflow flag of the timer is never touched from here
	assign timer_reset_out   = trst_q;
	assign match_flag_out    = st_q[ST_MATCH];
	assign irq_out           = |(st_q & mask_q[ST_W-1:0]);
	assign rdata_out         = rdata_q;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	sequence sev_armed_s;
		pend_q && timer_tick_in && !wr_val;
	endsequence

	sequence sev_cancel_s;
		pend_q && wr_val && !sev_ev;
	endsequence

	match_detect_a: assert property (
		cmp_mode && ({val_hi_q, val_lo_q} == timer_count_in) &&
		!$past(equal) |-> match_ev)
		else $error("equality not taken as match");
	toggle_action_a: assert property (
		match_ev && mode == MODE_TOGGLE && !wr_ctrl
		|=> compare_out != $past(compare_out))
		else $error("toggle mode did not toggle");
	set_clear_a: assert property (
		match_ev && (mode == MODE_SET || mode == MODE_CLEAR) &&
		!wr_ctrl |=> compare_out == ($past(mode) == MODE_SET))
		else $error("set or clear mode wrong level");
	flag_with_match_a: assert property (
		match_ev |=> match_flag_out)
		else $error("match flag not set");
	zero_ctrl_a: assert property (
		wr_ctrl && wdata_in == 8'h00 |=> !compare_out && !pin_drive_out)
		else $error("zero control write left latch high");
	no_pin_a: assert property (
		mode == MODE_SWI || mode == MODE_SEV |-> !pin_drive_out)
		else $error("pin claimed in interrupt or trigger mode");
	sev_trigger_a: assert property (
		sev_ev |=> special_event_out ##1 !special_event_out)
		else $error("trigger pulse missing or long");
	timer_reset_a: assert property (
		sev_armed_s |=> timer_reset_out ##1 !timer_reset_out)
		else $error("timer reset not issued on tick");
	reset_cancel_a: assert property (
		sev_cancel_s |=> !pend_q ##0 !timer_reset_out)
		else $error("value change did not cancel reset");
	std_bits_a: assert property (
		rd_in && addr_in == OFS_CTRL && !ENHANCED
		|=> rdata_out[7:6] == 2'h0)
		else $error("unimplemented control bits read nonzero");
	reset_state_a: assert property (
		$past(rst_in) |-> !compare_out && ctrl_q == CTRL_RST)
		else $error("reset did not clear control and latch");
endmodule
`default_nettype wire

/* File: tcmu_timer_model.sv */
// Timer model that feeds count and ticks to the compare unit
`timescale 1ns/1ns
`default_nettype none
module tcmu_timer_model (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        run_in,
	input  wire logic        load_in,
	input  wire logic        reset_req_in,
	output logic      [15:0] count_out,
	output logic             tick_out
);
	logic [1:0] div_q;
	// Ticks at a quarter of the clock, never the raw clock
	assign tick_out = run_in && div_q == 2'h0;
	always_ff @(posedge clk_in)
	begin
		div_q <= rst_in ? 2'h0 : div_q + 2'(run_in);
		if (rst_in || load_in || reset_req_in)
			count_out <= 16'h0000;
		else if (tick_out)
			count_out <= count_out + 16'h0001;
	end
endmodule
`default_nettype wire

/* File: test_timer_compare_match_unit.sv */
// Self-checking bench for the timer compare match unit
`timescale 1ns/1ns
`default_nettype none
module test_timer_compare_match_unit;
	import tcmu_pkg::*;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [2:0]  addr_in = 3'h0;
	logic [7:0]  wdata_in = 8'h00;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic        adc_enable_in = 1'b0;
	logic        run = 1'b0;
	logic        load = 1'b0;
	logic        exp_cmp = 1'b0;
	logic        hit;
	logic [3:0]  md;
	logic [7:0]  rdata_out, rdata_s, pin_route_a_out, pin_route_b_out;
	logic [15:0] timer_count_in;
	logic        timer_tick_in, compare_out, cmp_s, pin_drive_out;
	logic        special_event_out, adc_start_out, timer_reset_out;
	logic        match_flag_out, irq_out;
	logic [7:0]  reg_m [8] = '{default: 8'h00};
	logic [3:0]  modes [6] = '{MODE_TOGGLE, MODE_SET, MODE_CLEAR,
		MODE_TOGGLE, MODE_SWI, MODE_SEV};
	int          fail_count = 0;
	int          n_tests = 0;
	int          seed = 78;

	always #50 clk_in = ~clk_in;

	tcmu_unit #(.ENHANCED(1'b1)) dut_u (
		.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.timer_count_in, .timer_tick_in, .adc_enable_in, .compare_out,
		.pin_drive_out, .special_event_out, .adc_start_out,
		.timer_reset_out, .match_flag_out, .irq_out, .pin_route_a_out,
		.pin_route_b_out);
	tcmu_unit #(.ENHANCED(1'b0)) dut_s (
		.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out(rdata_s), .timer_count_in, .timer_tick_in,
		.adc_enable_in, .compare_out(cmp_s), .pin_drive_out(),
		.special_event_out(), .adc_start_out(), .timer_reset_out(),
		.match_flag_out(), .irq_out(), .pin_route_a_out(),
		.pin_route_b_out());
	tcmu_timer_model tmr_u (
		.clk_in, .rst_in, .run_in(run), .load_in(load),
		.reset_req_in(timer_reset_out), .count_out(timer_count_in),
		.tick_out(timer_tick_in));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Bus tasks start and end just after a rising edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		if (a == OFS_STATUS)
			reg_m[a] = reg_m[a] & ~d;
		else if (a == OFS_MASK)
			reg_m[a] = d & 8'h03;
		else if (a != 3'h7)
			reg_m[a] = d;
		// One idle edge so the strobe is never assigned twice at once
		@(posedge clk_in);
	endtask

	task automatic rd(input logic [2:0] a);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		check(rdata_out, reg_m[a]);
		check(rdata_s, a == 3'h0 ? reg_m[a] & 8'h3f : reg_m[a]);
		@(posedge clk_in);
	endtask

	// Returns at the falling edge of the cycle where the event shows
	task automatic await(input bit on_rst, input int lim);
		hit = 1'b0;
		for (int k = 0; k < lim && !hit; k++)
		begin
			@(negedge clk_in);
			hit = on_rst ? timer_reset_out === 1'b1 : match_flag_out === 1'b1;
		end
	endtask

	// Timer is held while the unit is set up so no match slips past
	task automatic arm(input logic [3:0] m, input logic [7:0] v);
		load <= 1'b1;
		@(posedge clk_in);
		load <= 1'b0;
		wr(OFS_VAL_LO, v);
		wr(OFS_VAL_HI, 8'h00);
		wr(OFS_STATUS, 8'h03);
		wr(OFS_CTRL, {4'h0, m});
		run <= 1'b1;
		await(1'b0, 300);
		if (hit)
			reg_m[3] = m == MODE_SEV ? 8'h03 : 8'h01;
		else
		begin
			fail_count++;
			print_verdict();
		end
	endtask

	initial
	begin
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		for (int a = 0; a < 8; a++)
			rd(3'(a));
		for (int a = 0; a < 8; a++)
			wr(3'(a), 8'hff);
		for (int a = 0; a < 8; a++)
			rd(3'(a));
		check(pin_route_a_out, 8'hff);
		check(pin_route_b_out, 8'hff);
		wr(OFS_CTRL, 8'h00);
		$display("register test done");
		for (int i = 0; i < 6; i++)
		begin
			md = modes[i];
			adc_enable_in <= 1'($random(seed));
			arm(md, 8'(8 + ($random(seed) & 15)));
			if (md == MODE_TOGGLE)
				exp_cmp = !exp_cmp;
			else if (md == MODE_SET || md == MODE_CLEAR)
				exp_cmp = md == MODE_SET;
			check(compare_out, exp_cmp);
			check(cmp_s, exp_cmp);
			check(pin_drive_out, md < MODE_SWI);
			check(special_event_out, md == MODE_SEV);
			check(adc_start_out, md == MODE_SEV && adc_enable_in);
			if (md == MODE_SEV)
			begin
				await(1'b1, 12);
				check(hit, 1'b1);
			end
			@(posedge clk_in);
			run <= 1'b0;
			rd(OFS_STATUS);
			rd(OFS_VAL_LO);
		end
		$display("compare mode test done");
		wr(OFS_CTRL, 8'h00);
		@(negedge clk_in);
		check(compare_out, 1'b0);
		@(posedge clk_in);
		wr(OFS_MASK, 8'h00);
		@(negedge clk_in);
		check(irq_out, 1'b0);
		@(posedge clk_in);
		wr(OFS_MASK, 8'h02);
		@(negedge clk_in);
		check(irq_out, 1'b1);
		@(posedge clk_in);
		wr(OFS_STATUS, 8'h02);
		@(negedge clk_in);
		check(irq_out, 1'b0);
		@(posedge clk_in);
		$display("interrupt test done");
		arm(MODE_SEV, 8'h10);
		@(posedge clk_in);
		wr(OFS_VAL_LO, 8'h0f);
		await(1'b1, 12);
		check(hit, 1'b0);
		$display("trigger cancel test done");
		print_verdict();
	end
endmodule
`default_nettype wire
